/* sar_adc_control_sequencer.v */
// sar converter control sequencer with apb register slave
//
// Functional notes
// - format bit 7: 1 right, 0 left justified
// - reference bit selects external pin or supply
// - channel field bits 4..2 selects inputs 0..6
// - writing go starts conversion; cleared on completion
// - go bit reads 1 while converting
// - enable bit 0 powers converter on or off
// - clock field bits 6..4 picks divider or oscillator
// - oscillator option independent clock, at most 500 kHz; the code instead divides pclk by OSC_DIV
// - unimplemented control bits read as zero
// - left layout: 9..2 high, 1..0 low 7..6
// - right layout: 9..8 high 1..0, 7..0 low
// - hold capacitor never discharged between conversions
// - completion clears go, sets flag, loads result
// - abort keeps result, waits two periods, reacquires
// - one conversion takes eleven conversion periods
// - oscillator source delays start one extra cycle
`include "sar_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_sequencer #(
   parameter OSC_DIV = `OSC_PERIOD_NS / `CLK_PERIOD_NS
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // analog front end
   input  wire        comparator_out,
   output reg         converter_enable,
   output reg         reference_select,
   output reg  [2:0]  channel_select,
   output reg         sample_enable,
   output reg  [9:0]  dac_code,
   output reg         completion_flag,
   input  wire        completion_flag_clear
);
   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_DELAY = 4'h2;
   localparam [3:0] ST_CONV  = 4'h4;
   localparam [3:0] ST_ABORT = 4'h8;

   reg  [7:0]  control_a_q;
   reg  [7:0]  clock_sel_q;
   reg  [9:0]  result_q;
   reg  [3:0]  state_q;
   reg  [3:0]  period_cnt_q;
   reg  [3:0]  bit_idx_q;
   reg  [9:0]  sar_q;
   reg  [15:0] div_cnt_q;
   reg  [15:0] div_lim;
   reg         comp_s1_q;
   reg         comp_s2_q;
   reg         clr_s1_q;
   reg         clr_s2_q;
   reg         clr_s3_q;
   wire        tick;
   wire        acc;
   wire        wr;
   wire        use_osc;
   wire [7:0]  rd_high;
   wire [7:0]  rd_low;
   wire        hit_ctl;
   wire        hit_clk;
   wire        hit_high;
   wire        hit_low;
   wire        done;
   reg  [7:0]  rd_byte;
   reg         rd_bad;

   function [15:0] divider_limit;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    divider_limit = 16'h0001;
            3'h4:    divider_limit = 16'h0003;
            3'h1:    divider_limit = 16'h0007;
            3'h5:    divider_limit = 16'h000f;
            3'h2:    divider_limit = 16'h001f;
            3'h6:    divider_limit = 16'h003f;
            default: divider_limit = OSC_DIV[15:0] - 16'h0001;
         endcase
      end
   endfunction

   // word offset match on the register address
   function addr_match;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         addr_match = addr == ofs;
      end
   endfunction

   // byte view of the result for one half of the pair
   function [7:0] result_byte;
      input       right;
      input       high;
      input [9:0] res;
      begin
         if (right) begin
            result_byte = high ? {6'h00, res[9:8]} : res[7:0];
         end else begin
            result_byte = high ? res[9:2] : {res[1:0], 6'h00};
         end
      end
   endfunction

   // one approximation step: settle bit idx-1, try bit idx-2
   function [9:0] sar_step;
      input [9:0] sar;
      input [3:0] idx;
      input       keep;
      reg   [9:0] nxt;
      begin
         nxt = sar;
         if (!keep) begin
            nxt[idx - 4'h1] = 1'b0;
         end
         if (idx > 4'h1) begin
            nxt[idx - 4'h2] = 1'b1;
         end
         sar_step = nxt;
      end
   endfunction

   assign acc     = psel & penable;
   assign wr      = acc & pwrite & pstrb[0];
   assign use_osc = clock_sel_q[`BIT_CLKSEL_LO+1:`BIT_CLKSEL_LO] == 2'h3;
   // result layout by format bit
   assign rd_high = result_byte(control_a_q[`BIT_FORMAT], 1'b1, result_q);
   assign rd_low  = result_byte(control_a_q[`BIT_FORMAT], 1'b0, result_q);
   // register decode, shared by the write paths
   assign hit_ctl  = addr_match(paddr, `OFS_CONTROL_A);
   assign hit_clk  = addr_match(paddr, `OFS_CLOCK_SELECT);
   assign hit_high = addr_match(paddr, `OFS_RESULT_HIGH);
   assign hit_low  = addr_match(paddr, `OFS_RESULT_LOW);
   assign done     = state_q == ST_CONV && control_a_q[`BIT_ENABLE] && tick
                     && period_cnt_q == `CONV_PERIODS - 4'h1;

   always @* begin
      div_lim = divider_limit(clock_sel_q[`BIT_CLKSEL_HI:`BIT_CLKSEL_LO]);
   end

   // read multiplexer
   always @* begin
      rd_byte = 8'h00;
      rd_bad  = 1'b0;
      case (paddr)
         `OFS_CONTROL_A:    rd_byte = control_a_q & `MASK_CONTROL_A;
         `OFS_CLOCK_SELECT: rd_byte = clock_sel_q & `MASK_CLOCK_SELECT;
         `OFS_RESULT_HIGH:  rd_byte = rd_high;
         `OFS_RESULT_LOW:   rd_byte = rd_low;
         default:           rd_bad  = 1'b1;
      endcase
   end

   // conversion clock period tick, free running
   assign tick = (div_cnt_q == div_lim);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 16'h0000;
      end else if (tick || div_cnt_q > div_lim) begin
         div_cnt_q <= 16'h0000;
      end else begin
         div_cnt_q <= div_cnt_q + 16'h0001;
      end
   end

   // synchronisers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_s1_q <= 1'b0;
         comp_s2_q <= 1'b0;
         clr_s1_q  <= 1'b0;
         clr_s2_q  <= 1'b0;
         clr_s3_q  <= 1'b0;
      end else begin
         comp_s1_q <= comparator_out;
         comp_s2_q <= comp_s1_q;
         clr_s1_q  <= completion_flag_clear;
         clr_s2_q  <= clr_s1_q;
         clr_s3_q  <= clr_s2_q;
      end
   end

   // apb read path
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            prdata  <= {24'h000000, rd_byte};
            pslverr <= rd_bad;
         end
      end
   end

   // completion flag: set wins over a clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         completion_flag <= 1'b0;
      end else if (done) begin
         completion_flag <= 1'b1;
      end else if (clr_s2_q && !clr_s3_q) begin
         completion_flag <= 1'b0;
      end
   end

   // conversion clock select, reserved bits held at zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_sel_q <= `RESET_CONTROL;
      end else if (wr && pready && hit_clk) begin
         clock_sel_q <= pwdata[7:0] & `MASK_CLOCK_SELECT;
      end
   end

   // front end controls, registered copies of the control state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_enable <= 1'b0;
         reference_select <= 1'b0;
         channel_select   <= 3'h0;
         sample_enable    <= 1'b0;
         dac_code         <= 10'h000;
      end else begin
         converter_enable <= control_a_q[`BIT_ENABLE];
         reference_select <= control_a_q[`BIT_REFERENCE];
         channel_select   <= (control_a_q[`BIT_CHAN_HI:`BIT_CHAN_LO] > `CHANNEL_LIMIT) ?
                             `CHANNEL_LIMIT : control_a_q[`BIT_CHAN_HI:`BIT_CHAN_LO];
         // sampler tracks between conversions, never discharged
         sample_enable    <= control_a_q[`BIT_ENABLE] & (state_q == ST_IDLE);
         dac_code         <= sar_q;
      end
   end

   // control registers and sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_a_q      <= `RESET_CONTROL;
         result_q         <= 10'h000;
         state_q          <= ST_IDLE;
         period_cnt_q     <= 4'h0;
         bit_idx_q        <= 4'h0;
         sar_q            <= 10'h000;
      end else begin
         if (wr && pready && hit_high) begin
            if (control_a_q[`BIT_FORMAT]) begin
               result_q[9:8] <= pwdata[1:0];
            end else begin
               result_q[9:2] <= pwdata[7:0];
            end
         end
         if (wr && pready && hit_low) begin
            if (control_a_q[`BIT_FORMAT]) begin
               result_q[7:0] <= pwdata[7:0];
            end else begin
               result_q[1:0] <= pwdata[7:6];
            end
         end
         if (wr && pready && hit_ctl) begin
            // go only latched when enabled
            control_a_q <= pwdata[7:0] & `MASK_CONTROL_A
                           & {6'h3f, pwdata[`BIT_ENABLE] & control_a_q[`BIT_ENABLE], 1'b1};
            if (pwdata[`BIT_GO] && control_a_q[`BIT_ENABLE] && state_q == ST_IDLE) begin
               state_q      <= ST_DELAY;
               period_cnt_q <= 4'h0;
               bit_idx_q    <= `BIT_COUNT;
               sar_q        <= 10'h000;
            end
            if (!pwdata[`BIT_GO] && control_a_q[`BIT_GO] && (state_q == ST_CONV || state_q == ST_DELAY)) begin
               state_q      <= ST_ABORT;
               period_cnt_q <= 4'h0;
            end
         end
         case (state_q)
            ST_IDLE: begin
            end
            ST_DELAY: begin
               // one system cycle extra for oscillator source
               if (!use_osc || period_cnt_q != 4'h0) begin
                  state_q      <= ST_CONV;
                  period_cnt_q <= 4'h0;
                  sar_q        <= 10'h200;
               end else begin
                  period_cnt_q <= 4'h1;
               end
            end
            ST_CONV: begin
               if (!control_a_q[`BIT_ENABLE]) begin
                  state_q                <= ST_IDLE;
                  control_a_q[`BIT_GO]   <= 1'b0;
               end else if (tick) begin
                  period_cnt_q <= period_cnt_q + 4'h1;
                  if (period_cnt_q != 4'h0 && bit_idx_q != 4'h0) begin
                     // resolve one bit per period
                     sar_q <= sar_step(sar_q, bit_idx_q, comp_s2_q);
                     bit_idx_q <= bit_idx_q - 4'h1;
                  end
                  if (period_cnt_q == `CONV_PERIODS - 4'h1) begin
                     state_q              <= ST_IDLE;
                     control_a_q[`BIT_GO] <= 1'b0;
                     // last bit decision folded into the stored result
                     result_q             <= sar_step(sar_q, bit_idx_q, comp_s2_q);
                  end
               end
            end
            ST_ABORT: begin
               if (tick) begin
                  period_cnt_q <= period_cnt_q + 4'h1;
                  if (period_cnt_q == `ABORT_PERIODS - 4'h1) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* sar_consts.vh */
// register offsets, field positions and timing constants of the converter control block
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH
`define OFS_CONTROL_A      12'h000
`define OFS_CLOCK_SELECT   12'h004
`define OFS_RESULT_HIGH    12'h008
`define OFS_RESULT_LOW     12'h00c
`define BIT_FORMAT         7
`define BIT_REFERENCE      6
`define BIT_CHAN_HI        4
`define BIT_CHAN_LO        2
`define BIT_GO             1
`define BIT_ENABLE         0
`define BIT_CLKSEL_HI      6
`define BIT_CLKSEL_LO      4
`define MASK_CONTROL_A     8'hdf
`define MASK_CLOCK_SELECT  8'h70
`define RESET_CONTROL      8'h00
`define CONV_PERIODS       4'hb
`define ABORT_PERIODS      4'h2
`define BIT_COUNT          4'ha
`define CHANNEL_LIMIT      3'h6
`define OSC_PERIOD_NS      2000
`define CLK_PERIOD_NS      25
`endif

/* sar_adc_control_sequencer_assertions.sv */
// port assertions for the converter control sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_seq_checker (
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // converter
   input wire logic        converter_enable,
   input wire logic        reference_select,
   input wire logic [2:0]  channel_select,
   input wire logic        sample_enable,
   input wire logic        completion_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] ctl_q;
   wire        wr_ctl = psel && penable && pready && pwrite && paddr == 12'h000;
   always @(posedge pclk or negedge presetn)
      if (!presetn) ctl_q <= 8'h00;
      else if (wr_ctl) ctl_q <= pwdata[7:0];
   AST_ACCESS_ANSWER:
      assert property ((psel && !penable) ##1 (psel && penable) |-> pready) else $error("no answer");
   AST_READY_PULSE:
      assert property (pready |=> !pready) else $error("ready held");
   AST_UNMAPPED_ERR:
      assert property (pready |-> pslverr == (paddr > 12'h00c)) else $error("bad error flag");
   AST_CTL_RESERVED:
      assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0
         && !prdata[5]) else $error("control reserved bits set");
   AST_CLK_RESERVED:
      assert property (pready && !pwrite && paddr == 12'h004 |-> (prdata & ~32'h70) == 32'h0)
         else $error("clock reserved bits set");
   AST_REF_MIRROR:
      assert property (wr_ctl |-> ##2 reference_select == ctl_q[6]) else $error("reference");
   AST_EN_MIRROR:
      assert property (wr_ctl |-> ##2 converter_enable == ctl_q[0]) else $error("enable");
   AST_CHAN_MIRROR:
      assert property (wr_ctl |-> ##2 channel_select == ((ctl_q[4:2] == 3'h7) ? 3'h6
         : ctl_q[4:2])) else $error("channel");
   AST_DISABLED_IDLE:
      assert property (!converter_enable && $past(!converter_enable) |-> !sample_enable
         && !$rose(completion_flag)) else $error("active while disabled");
   AST_FLAG_AT_DONE:
      assert property ($rose(completion_flag) |-> $past(!sample_enable)) else $error("flag");
endmodule
bind sar_adc_control_sequencer sar_seq_checker chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .converter_enable(converter_enable),
   .reference_select(reference_select), .channel_select(channel_select),
   .sample_enable(sample_enable), .completion_flag(completion_flag));
`default_nettype wire

/* sar_analog_model.sv */
// analog front end stand-in: tracks the selected input, compares with the trial code
`timescale 1ns/10ps
`default_nettype none
module sar_analog_model (
   // converter side
   input  wire logic       pclk,
   input  wire logic [2:0] channel_select,
   input  wire logic       sample_enable,
   input  wire logic [9:0] dac_code,
   output logic            comparator_out
);
   logic [9:0] held_q = 10'h000;
   // held level is never discharged, only retracked
   always @(posedge pclk)
      if (sample_enable) held_q <= 10'h0a5 + 10'h053 * {7'h00, channel_select};
   // input sits half a step above its code
   assign comparator_out = held_q >= dac_code;
endmodule
`default_nettype wire

/* sar_adc_control_sequencer_tb.sv */
// self-checking bench for the converter control sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_sequencer_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, comparator_out, converter_enable, reference_select, err;
   logic        sample_enable, completion_flag, flag_clear = 1'b0;
   logic [2:0]  channel_select;
   logic [9:0]  dac_code;
   int          n_errors = 0, compares = 0, cyc = 0;
   sar_adc_control_sequencer #(.OSC_DIV(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_out(comparator_out),
      .converter_enable(converter_enable), .reference_select(reference_select),
      .channel_select(channel_select), .sample_enable(sample_enable), .dac_code(dac_code),
      .completion_flag(completion_flag), .completion_flag_clear(flag_clear));
   sar_analog_model fe (.pclk(pclk), .channel_select(channel_select),
      .sample_enable(sample_enable), .dac_code(dac_code), .comparator_out(comparator_out));
   initial forever #12.5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   task automatic give_verdict;
      $display("counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_regs;
      apb(0, 12'h000, 0); chk("control_a reset", 32'h0, rd);
      apb(0, 12'h004, 0); chk("clock_select reset", 32'h0, rd);
      apb(1, 12'h000, 32'hffffffff);
      apb(0, 12'h000, 0); chk("control_a masked", 32'hdd, rd);
      apb(1, 12'h004, 32'hffffffff);
      apb(0, 12'h004, 0); chk("clock_select masked", 32'h70, rd);
      apb(1, 12'h000, 0);
      apb(0, 12'h010, 0); chk("unmapped error", 32'h1, {31'h0, err});
      $display("test regs done");
   endtask
   task automatic t_conv(input logic [2:0] cs, input logic fmt, input logic [2:0] ch);
      logic [9:0] v;
      int d, t0;
      v = 10'h0a5 + 10'h053 * {7'h00, ch};
      d = (cs[1:0] == 2'b11) ? 4 : 2 << (2 * cs[1:0] + cs[2]);
      apb(1, 12'h004, {25'h0, cs, 4'h0});
      apb(1, 12'h000, {24'h0, fmt, 2'b00, ch, 2'b01});
      repeat (20) @(posedge pclk);
      apb(1, 12'h000, {24'h0, fmt, 2'b00, ch, 2'b11});
      t0 = cyc;
      apb(0, 12'h000, 0); chk("go busy", 32'h2, rd & 32'h2);
      while (rd[1] !== 1'b0) apb(0, 12'h000, 0);
      chk("length", 32'h1, {31'h0, cyc - t0 >= 10 * d && cyc - t0 <= 11 * d + 8});
      chk("flag set", 32'h1, {31'h0, completion_flag});
      apb(0, 12'h008, 0);
      chk("high", fmt ? v[9:8] : v[9:2], fmt ? rd & 32'h3 : rd);
      apb(0, 12'h00c, 0);
      chk("low", fmt ? v[7:0] : {v[1:0], 6'h0}, fmt ? rd : rd & 32'hc0);
      flag_clear <= 1'b1;
      repeat (4) @(posedge pclk);
      flag_clear <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("flag cleared", 32'h0, {31'h0, completion_flag});
      $display("test conv %0d done", cs);
   endtask
   task automatic t_abort;
      apb(1, 12'h000, 32'h85);
      repeat (20) @(posedge pclk);
      apb(1, 12'h000, 32'h87);
      repeat (10) @(posedge pclk);
      apb(1, 12'h000, 32'h85);
      repeat (200) @(posedge pclk);
      chk("tracking again", 32'h1, {31'h0, sample_enable});
      chk("no flag", 32'h0, {31'h0, completion_flag});
      apb(0, 12'h008, 0); chk("high kept", 32'h0, rd & 32'h3);
      apb(0, 12'h00c, 0); chk("low kept", 32'ha5, rd);
      $display("test abort done");
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      // divide by 2 is faster than the comparator synchroniser; /4 runs twice
      for (int i = 0; i < 8; i++) t_conv((i == 0) ? 3'h4 : i[2:0], i[0], 3'(i % 7));
      t_abort();
      give_verdict();
   end
   initial begin
      #(25 * 20000);
      n_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
